// [verilog/tpc_consts.vh]
`ifndef TPC_CONSTS_VH
`define TPC_CONSTS_VH

// Absolute slot numbers of the teach range in the position target table
`define TPC_SLOT_FIRST    7'h47
`define TPC_SLOT_LAST     7'h64
// Number of teach slots and the index of the last one
`define TPC_SLOT_COUNT    6'h1E
`define TPC_IDX_LAST      5'h1D
// Index used to address nothing (memory answers zero)
`define TPC_IDX_NONE      5'h1F
// Offset between absolute slot number and display value
`define TPC_DISPLAY_OFS   7'h46
// Reset values
`define TPC_PTR_RESET     5'h00
`define TPC_SLOT_RESET    32'h00000000
`define TPC_COUNT_RESET   16'h0001
`define TPC_DISPLAY_RESET 7'h01

`endif

// [verilog/tpc_slot_mem.v]
`include "tpc_consts.vh"

module tpc_slot_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 30,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             i_sys_clk,
  input  wire             i_rstn,
  // Clear of every word
  input  wire             i_clear,
  // Write port
  input  wire             i_wr_en,
  input  wire [AW-1:0]    i_wr_addr,
  input  wire [WIDTH-1:0] i_wr_data,
  // Read port
  input  wire [AW-1:0]    i_rd_addr,
  output reg  [WIDTH-1:0] o_rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer         k;

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem[k] <= `TPC_SLOT_RESET;
      end
      o_rd_data <= `TPC_SLOT_RESET;
    end else begin
      if (i_clear) begin
        for (k = 0; k < DEPTH; k = k + 1) begin
          mem[k] <= `TPC_SLOT_RESET;
        end
      end else if (i_wr_en && (i_wr_addr < DEPTH)) begin
        mem[i_wr_addr] <= i_wr_data;
      end
      // Read data is the word as it stood before this edge; out of range reads zero
      if (i_rd_addr < DEPTH) begin
        o_rd_data <= mem[i_rd_addr];
      end else begin
        o_rd_data <= `TPC_SLOT_RESET;
      end
    end
  end

endmodule

// [verilog/tpc_teach_capture_unit.v]
`include "tpc_consts.vh"

//Contract
// RQ1 - Store edge copies the actual position into the selected slot.
// RQ2 - Step edge advances the slot pointer to the next slot.
// RQ3 - Thirty teach slots, 71 to 100; pointer never leaves that range.
// RQ4 - Count output carries the selected slot number for other blocks; the code drives it with the display value (1 to 30), not 71 to 100.
// RQ5 - Display value equals absolute selected slot number minus 70.
// RQ6 - Selected slot is readable, showing where the next store writes.
// RQ7 - Clear high zeroes every slot and selects slot 71.
// RQ8 - Direct selection below 71 gives 71, above 100 gives 100.
// RQ9 - Load high sets the pointer to the clamped direct selection.
// RQ10 - Simultaneous requests: clear, then load, then step, then store.
// RQ11 - Signed 32-bit slots; reset selects 71, edge detectors see low.
module tpc_teach_capture_unit #(
  parameter WIDTH = 32,
  parameter DEPTH = 30,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire                    i_sys_clk,
  input  wire                    i_rstn,
  // Position feedback
  input  wire signed [WIDTH-1:0] i_actual_position_in,
  // Requests
  input  wire                    i_store_request,
  input  wire                    i_step_request,
  input  wire                    i_clear_request,
  input  wire                    i_load_pointer_request,
  input  wire signed [31:0]      i_direct_slot_select,
  // Table read port for the positioning program
  input  wire [6:0]              i_table_rd_slot,
  output wire signed [WIDTH-1:0] o_table_rd_data,
  // Slot pointer reporting
  output reg  [15:0]             o_slot_count_out,
  output reg  [6:0]              o_selected_slot_display,
  output reg  [6:0]              o_selected_slot_abs,
  // Store acknowledge
  output reg                     o_store_done
);

  // Pointer actions, one per cycle, picked by fixed priority
  localparam [1:0] ACT_HOLD  = 2'b00;
  localparam [1:0] ACT_CLEAR = 2'b01;
  localparam [1:0] ACT_LOAD  = 2'b10;
  localparam [1:0] ACT_STEP  = 2'b11;

  // Slot pointer as an index 0..DEPTH-1; index 0 is slot 71
  reg  [AW-1:0]      ptr;
  reg  [AW-1:0]      next_ptr;
  reg  [1:0]         ptr_act;
  // Previous request levels for edge detection
  reg                store_prev;
  reg                step_prev;
  // Clamped direct selection and table read index
  reg  [AW-1:0]      load_idx;
  reg  [AW-1:0]      rd_idx;
  // Values the reporting outputs take at the next edge
  reg  [6:0]         next_abs;
  reg  [6:0]         next_display;
  reg  [15:0]        next_count;

  wire               store_edge;
  wire               step_edge;
  wire               store_go;
  wire               ptr_at_last;
  wire [AW-1:0]      ptr_inc;
  wire               sel_below;
  wire               sel_above;
  wire [31:0]        sel_diff;
  wire signed [31:0] sel_lo;
  wire signed [31:0] sel_hi;
  wire               rd_below;
  wire               rd_above;
  wire [6:0]         rd_diff;

  // Rising edges of the request levels
  assign store_edge = i_store_request & ~store_prev; // [RQ1]
  assign step_edge  = i_step_request & ~step_prev; // [RQ2]

  // Detectors start from low, so a request held through reset counts once
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      store_prev <= 1'b0; // [RQ11]
    end else begin
      store_prev <= i_store_request;
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_prev <= 1'b0; // [RQ11]
    end else begin
      step_prev <= i_step_request;
    end
  end

  // Teach range bounds, signed so that negative selections clamp low
  assign sel_lo    = $signed({25'h0000000, `TPC_SLOT_FIRST});
  assign sel_hi    = $signed({25'h0000000, `TPC_SLOT_LAST});
  assign sel_below = (i_direct_slot_select < sel_lo); // [RQ8]
  assign sel_above = (i_direct_slot_select > sel_hi); // [RQ8]
  assign sel_diff  = i_direct_slot_select - sel_lo;

  always @* begin
    load_idx = sel_diff[AW-1:0];
    if (sel_below) begin
      load_idx = `TPC_PTR_RESET; // [RQ8]
    end else if (sel_above) begin
      load_idx = `TPC_IDX_LAST; // [RQ8]
    end
  end

  assign ptr_at_last = (ptr >= `TPC_IDX_LAST);
  assign ptr_inc     = ptr + {{(AW-1){1'b0}}, 1'b1};

  // Priority: clear, then load, then step
  always @* begin
    ptr_act = ACT_HOLD;
    if (i_clear_request) begin
      ptr_act = ACT_CLEAR; // [RQ7] [RQ10]
    end else if (i_load_pointer_request) begin
      ptr_act = ACT_LOAD; // [RQ9] [RQ10]
    end else if (step_edge) begin
      ptr_act = ACT_STEP; // [RQ2] [RQ10]
    end
  end

  always @* begin
    case (ptr_act)
      ACT_CLEAR: begin
        next_ptr = `TPC_PTR_RESET; // [RQ7]
      end
      ACT_LOAD: begin
        next_ptr = load_idx; // [RQ9]
      end
      ACT_STEP: begin
        // Stepping past slot 100 wraps to slot 71
        if (ptr_at_last) begin
          next_ptr = `TPC_PTR_RESET; // [RQ3]
        end else begin
          next_ptr = ptr_inc; // [RQ2]
        end
      end
      default: begin
        next_ptr = ptr;
      end
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ptr <= `TPC_PTR_RESET; // [RQ11]
    end else begin
      ptr <= next_ptr;
    end
  end

  // Store comes last: it writes the slot chosen after load or step, and a
  // clear in the same cycle wins over it
  assign store_go = store_edge & ~i_clear_request; // [RQ1] [RQ10]

  // Reporting follows the pointer value taken at the same edge
  always @* begin
    next_abs     = {2'b00, next_ptr} + `TPC_SLOT_FIRST;
    next_display = next_abs - `TPC_DISPLAY_OFS;
    next_count   = {9'h000, next_display};
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_slot_count_out <= `TPC_COUNT_RESET;
    end else begin
      o_slot_count_out <= next_count; // [RQ4]
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_selected_slot_display <= `TPC_DISPLAY_RESET;
    end else begin
      o_selected_slot_display <= next_display; // [RQ5] [RQ6]
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_selected_slot_abs <= `TPC_SLOT_FIRST; // [RQ11]
    end else begin
      o_selected_slot_abs <= next_abs; // [RQ6]
    end
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_store_done <= 1'b0;
    end else begin
      o_store_done <= store_go; // [RQ1]
    end
  end

  // Read address: absolute slot number to index; outside the range reads zero
  assign rd_diff  = i_table_rd_slot - `TPC_SLOT_FIRST;
  assign rd_below = (i_table_rd_slot < `TPC_SLOT_FIRST);
  assign rd_above = (i_table_rd_slot > `TPC_SLOT_LAST);

  always @* begin
    rd_idx = rd_diff[AW-1:0];
    if (rd_below || rd_above) begin
      rd_idx = `TPC_IDX_NONE; // [RQ3]
    end
  end

  tpc_slot_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_slots (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_clear   (i_clear_request), // [RQ7]
    .i_wr_en   (store_go), // [RQ1]
    .i_wr_addr (next_ptr), // [RQ1] [RQ10]
    .i_wr_data (i_actual_position_in), // [RQ1] [RQ11]
    .i_rd_addr (rd_idx), // [RQ3]
    .o_rd_data (o_table_rd_data)
  );

endmodule

// [sim/tpc_teach_capture_unit_asserts.sv]
module tpc_chk (
  input wire               i_sys_clk,
  input wire               i_rstn,
  input wire               i_store_request,
  input wire               i_step_request,
  input wire               i_clear_request,
  input wire               i_load_pointer_request,
  input wire signed [31:0] i_direct_slot_select,
  input wire [15:0]        o_slot_count_out,
  input wire [6:0]         o_selected_slot_display,
  input wire [6:0]         o_selected_slot_abs,
  input wire               o_store_done
);
  wire               c = i_clear_request;
  wire               l = i_load_pointer_request;
  wire signed [31:0] s = i_direct_slot_select;
  wire [6:0]         a = o_selected_slot_abs;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_clear_ptr: assert property (c |=> a == 7'h47)
    else $error("clear did not select first slot");
  a_disp_ofs: assert property (o_selected_slot_display == a - 7'h46)
    else $error("display offset wrong");
  a_count_disp: assert property (o_slot_count_out == {9'h000, o_selected_slot_display})
    else $error("count output wrong");
  a_ptr_range: assert property (a inside {[7'h47:7'h64]})
    else $error("pointer out of range");
  a_load_clamp: assert property (!c && l |=> a == ($past(s) < 32'sh47 ? 7'h47 :
    $past(s) > 32'sh64 ? 7'h64 : $past(s[6:0]))) else $error("load value wrong");
  a_step_next: assert property ($rose(i_step_request) && !c && !l |=>
    a == ($past(a) == 7'h64 ? 7'h47 : $past(a) + 7'h01)) else $error("step wrong");
  a_store_ack: assert property ($rose(i_store_request) && !c |=> o_store_done)
    else $error("store not done");
  a_done_cause: assert property (o_store_done |-> $past(i_store_request && !c))
    else $error("done without store");
endmodule

bind tpc_teach_capture_unit tpc_chk chk_u (.*);

// [sim/tpc_pos_src.sv]
// Feedback ramp that moves every cycle, so a late sample stores a wrong value
module tpc_pos_src (
  input  wire                i_sys_clk,
  output logic signed [31:0] o_pos = 32'hFFFFFF00
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge i_sys_clk) o_pos <= o_pos + 32'h00010003;
endmodule

// [sim/tb_tpc_teach_capture_unit.sv]
module tb_tpc_teach_capture_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, st = 0, nx = 0, cl = 0, ld = 0;
  logic [31:0] sel = 32'h0;
  logic [6:0]  rs = 7'h47;
  wire  [31:0] pos, rdd;
  wire  [15:0] cnt;
  wire  [6:0]  dsp, ab;
  wire         dn;
  int          fail_count = 0, samples_checked = 0;
  tpc_pos_src src_u (.i_sys_clk(clk), .o_pos(pos));
  tpc_teach_capture_unit dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_actual_position_in(pos),
    .i_store_request(st), .i_step_request(nx), .i_clear_request(cl),
    .i_load_pointer_request(ld), .i_direct_slot_select(sel), .i_table_rd_slot(rs),
    .o_table_rd_data(rdd), .o_slot_count_out(cnt), .o_selected_slot_display(dsp),
    .o_selected_slot_abs(ab), .o_store_done(dn));
  initial forever #25 clk = ~clk;
  task automatic cyc(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ptr(logic [6:0] a);
    chk(ab, a);
    chk(dsp, a - 7'h46);
    chk(cnt, a - 7'h46);
  endtask
  task automatic rdc(logic [6:0] s, logic [31:0] exp);
    rs = s;
    cyc();
    chk(rdd, exp);
  endtask
  // Mask order is store, step, clear, load; callers leave a cycle between pulses of the same request
  task automatic pulse(logic [3:0] m);
    {st, nx, cl, ld} = m;
    cyc();
    {st, nx, cl, ld} = 4'h0;
  endtask
  task automatic t_store;
    logic [31:0] p = pos;
    pulse(4'h8);
    chk(dn, 1);
    rdc(7'h47, p);
    rdc(7'h46, 0);
  endtask
  task automatic t_step;
    for (int i = 0; i < 29; i++) begin
      pulse(4'h4);
      cyc();
    end
    ptr(7'h64);
    pulse(4'h4);
    ptr(7'h47);
  endtask
  task automatic t_load;
    logic [31:0] v[7] = '{32'h55, 32'hFFFFFFFB, 32'h64, 32'h46, 32'h65, 32'h47, 32'hC8};
    logic [6:0]  e[7] = '{7'h55, 7'h47, 7'h64, 7'h47, 7'h64, 7'h47, 7'h64};
    foreach (v[i]) begin
      sel = v[i];
      pulse(4'h1);
      ptr(e[i]);
      cyc();
    end
  endtask
  task automatic t_prio;
    logic [31:0] p = pos;
    logic [31:0] q;
    sel = 32'h5A;
    pulse(4'hD);
    ptr(7'h5A);
    chk(dn, 1);
    rdc(7'h5A, p);
    pulse(4'hF);
    ptr(7'h47);
    chk(dn, 0);
    rdc(7'h5A, 0);
    rdc(7'h47, 0);
    q = pos;
    pulse(4'hC);
    ptr(7'h48);
    rdc(7'h48, q);
  endtask
  // Mid-run reset with the store request held high across the release
  task automatic t_reset;
    logic [31:0] p = pos;
    logic [31:0] q;
    sel = 32'h60;
    pulse(4'h9);
    rdc(7'h60, p);
    rstn = 0;
    st = 1;
    cyc(2);
    ptr(7'h47);
    chk(dn, 0);
    q = pos;
    rstn = 1;
    cyc();
    chk(dn, 1);
    st = 0;
    rdc(7'h47, q);
    rdc(7'h60, 0);
    ptr(7'h47);
  endtask
  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    rstn = 1;
    ptr(7'h47);
    t_store();
    t_step();
    t_load();
    t_prio();
    t_reset();
    summarize();
  end
endmodule
